// ===== rtl/ldfc_core.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module ldfc_core import ldfc_pkg::*; #(
  parameter longint LAMP_OUT_CYCLES = LAMP_OUT_CYC
) (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Brightness interface samples
  input wire logic [ADC_W-1:0] brightness_control_input,
  input wire logic [ADC_W-1:0] brightness_reference_input,
  input wire logic mode_negative_scale,
  input wire logic mode_sync_pulse,
  input wire ldfc_min_e min_level_setting,
  // Shutdown requests and supervision
  input wire logic shutdown_suspend_pin_n,
  input wire logic mode_reg_shutdown,
  input wire logic rail_undervoltage,
  input wire logic lamp_current_sense,
  input wire logic buck_short_detect,
  // Lamp drive
  output logic [CODE_W-1:0] brightness_code,
  output logic [CODE_W-1:0] current_code,
  output logic chopping_pwm,
  output logic buck_gate_en,
  // Status
  output logic shutdown_active,
  output ldfc_fault_s fault_latch,
  output logic lamp_status_flag
);

  // ---------------------------------------------------------------
  // Hysteretic converter
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] adc_code_r, adc_code_nxt, scale_pos;
  logic [PROD_W-1:0] ctl_scaled, up_thr, dn_thr;

  // Negative scale is the positive ladder mirrored, so one compare pair serves both
  assign scale_pos = mode_negative_scale ? (CODE_MAX - adc_code_r) : adc_code_r;
  assign ctl_scaled = PROD_W'(SCALE_DIV) * PROD_W'(brightness_control_input);
  assign up_thr = PROD_W'({1'b0, scale_pos} + HYST_UP) * PROD_W'(brightness_reference_input);
  assign dn_thr = PROD_W'(scale_pos) * PROD_W'(brightness_reference_input);

  // One step per clock; a full sweep settles well inside one period
  always_comb begin
    adc_code_nxt = adc_code_r;
    if (ctl_scaled > up_thr && scale_pos != CODE_MAX) begin
      adc_code_nxt = mode_negative_scale ? adc_code_r - 5'h01 : adc_code_r + 5'h01;
    end else if (ctl_scaled < dn_thr) begin
      adc_code_nxt = mode_negative_scale ? adc_code_r + 5'h01 : adc_code_r - 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adc_code_r <= CODE_RST;
    end else begin
      adc_code_r <= adc_code_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Chopping period from sync pulses
  // ---------------------------------------------------------------
  logic sync_d_r, sync_d_nxt, sync_edge, boundary;
  logic [PCNT_W-1:0] pcnt_r, pcnt_nxt;
  logic [CODE_W-1:0] code_r, code_nxt;

  assign sync_edge = mode_sync_pulse & ~sync_d_r;
  assign boundary = sync_edge && pcnt_r == PCNT_LAST;

  // Latching at the boundary keeps duty and current steady within a period
  always_comb begin
    sync_d_nxt = mode_sync_pulse;
    pcnt_nxt = pcnt_r;
    code_nxt = code_r;
    if (sync_edge) begin
      pcnt_nxt = boundary ? '0 : pcnt_r + 8'h01;
    end
    if (boundary) begin
      code_nxt = adc_code_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_d_r <= 1'b1; // A pin idling high gives no false first pulse
      pcnt_r <= '0;
      code_r <= CODE_RST;
    end else begin
      sync_d_r <= sync_d_nxt;
      pcnt_r <= pcnt_nxt;
      code_r <= code_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Sense filter and lamp-out timer
  // ---------------------------------------------------------------
  logic [FCNT_W-1:0] fcnt_r, fcnt_nxt;
  logic [TCNT_W-1:0] tcnt_r, tcnt_nxt;
  logic sense_valid, timeout, shdn_req;
  ldfc_state_e state_r, state_nxt;
  ldfc_fault_s flt_r, flt_nxt;
  logic status_r, status_nxt, shdn_r, shdn_nxt;

  assign shdn_req = ~shutdown_suspend_pin_n | mode_reg_shutdown;
  // Sense must stay high a full filter window; shorter glitches never count
  assign sense_valid = lamp_current_sense && fcnt_r == FILT_LAST;
  assign timeout = tcnt_r == TCNT_W'(LAMP_OUT_CYCLES - 1);

  always_comb begin
    fcnt_nxt = '0;
    if (lamp_current_sense && fcnt_r != FILT_LAST) begin
      fcnt_nxt = fcnt_r + 6'h01;
    end else if (lamp_current_sense) begin
      fcnt_nxt = fcnt_r;
    end
  end

  // Run, shutdown and latched fault; a fault holds until shutdown is entered
  always_comb begin
    state_nxt = state_r;
    flt_nxt = flt_r;
    status_nxt = status_r;
    tcnt_nxt = tcnt_r + 29'h1;
    unique case (state_r)
      ST_RUN: begin
        if (shdn_req) begin
          state_nxt = ST_SHDN;
          tcnt_nxt = '0;
        end else if (timeout) begin
          state_nxt = ST_FAULT;
          flt_nxt.lamp_out = 1'b1;
          status_nxt = 1'b1;
          tcnt_nxt = '0;
        end else if (buck_short_detect) begin
          state_nxt = ST_FAULT;
          flt_nxt.buck_short = 1'b1;
        end else if (sense_valid) begin
          tcnt_nxt = '0;
        end
      end
      ST_SHDN: begin
        tcnt_nxt = '0;
        flt_nxt = '0;
        if (!shdn_req) begin
          state_nxt = ST_RUN;
        end
      end
      ST_FAULT: begin
        tcnt_nxt = '0;
        if (shdn_req) begin
          state_nxt = ST_SHDN;
        end
      end
      default: begin
        state_nxt = ST_SHDN;
        tcnt_nxt = '0;
      end
    endcase
    shdn_nxt = (state_nxt == ST_SHDN);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fcnt_r <= '0;
      tcnt_r <= '0;
      state_r <= ST_RUN;
      flt_r <= '0;
      status_r <= 1'b0;
      shdn_r <= 1'b0;
    end else begin
      fcnt_r <= fcnt_nxt;
      tcnt_r <= tcnt_nxt;
      state_r <= state_nxt;
      flt_r <= flt_nxt;
      status_r <= status_nxt;
      shdn_r <= shdn_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Duty, current and output registers
  // ---------------------------------------------------------------
  logic [PCNT_W-1:0] on_len;
  logic pwm_r, pwm_nxt, gate_r, gate_nxt;
  logic [CODE_W-1:0] cur_r, cur_nxt;

  // Floor region is flat, so the step from code 3 to 4 is larger than the rest
  assign on_len = (code_r <= FLOOR_CODE) ? DUTY_FLOOR
                : PCNT_W'(({3'h0, code_r} + 8'h01) * DUTY_STEP);

  always_comb begin
    cur_nxt = code_r;
    pwm_nxt = pcnt_r < on_len;
    unique case (min_level_setting)
      MIN_AT_RAIL: pwm_nxt = 1'b1;
      MIN_AT_REF: cur_nxt = CODE_MAX;
      MIN_BETWEEN: cur_nxt = code_r;
      default: cur_nxt = code_r;
    endcase
    if (state_r != ST_RUN) begin
      pwm_nxt = 1'b0;
    end
    gate_nxt = pwm_nxt & ~rail_undervoltage;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_r <= 1'b0;
      gate_r <= 1'b0;
      cur_r <= CODE_RST;
    end else begin
      pwm_r <= pwm_nxt;
      gate_r <= gate_nxt;
      cur_r <= cur_nxt;
    end
  end

  assign brightness_code = code_r;
  assign current_code = cur_r;
  assign chopping_pwm = pwm_r;
  assign buck_gate_en = gate_r;
  assign shutdown_active = shdn_r;
  assign fault_latch = flt_r;
  assign lamp_status_flag = status_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_uvlo_gate;
    rail_undervoltage |=> !buck_gate_en;
  endproperty
  a_uvlo_gate: assert property (p_uvlo_gate) else $error("gate on in lockout");
  property p_code_at_boundary;
    !boundary |=> $stable(brightness_code);
  endproperty
  a_code_at_boundary: assert property (p_code_at_boundary) else $error("code moved");
  property p_rail_full_duty;
    (min_level_setting == MIN_AT_RAIL && state_r == ST_RUN) |=> chopping_pwm;
  endproperty
  a_rail_full_duty: assert property (p_rail_full_duty) else $error("chopping at rail");
  property p_ref_max_current;
    min_level_setting == MIN_AT_REF |=> current_code == CODE_MAX;
  endproperty
  a_ref_max_current: assert property (p_ref_max_current) else $error("current not max");
  property p_shdn_clears;
    state_r == ST_SHDN |=> fault_latch == '0;
  endproperty
  a_shdn_clears: assert property (p_shdn_clears) else $error("fault kept in shutdown");
  property p_pin_shutdown;
    (!shutdown_suspend_pin_n && state_r != ST_SHDN) |=> shutdown_active;
  endproperty
  a_pin_shutdown: assert property (p_pin_shutdown) else $error("pin ignored");
  sequence s_timeout_hit;
    state_r == ST_RUN && !shdn_req && timeout;
  endsequence
  property p_lamp_out;
    s_timeout_hit |=> fault_latch.lamp_out && lamp_status_flag ##1 !chopping_pwm;
  endproperty
  a_lamp_out: assert property (p_lamp_out) else $error("lamp-out not latched");
  property p_short_pulse;
    !lamp_current_sense ##1 lamp_current_sense [*8] |-> !sense_valid;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("glitch accepted");
  property p_period_len;
    boundary |=> pcnt_r == '0;
  endproperty
  a_period_len: assert property (p_period_len) else $error("period count wrong");
  property p_floor_duty;
    brightness_code <= FLOOR_CODE |-> on_len == DUTY_FLOOR;
  endproperty
  a_floor_duty: assert property (p_floor_duty) else $error("floor duty wrong");

endmodule // ldfc_core

// ===== rtl/ldfc_pkg.sv
package ldfc_pkg;
  // ---------------------------------------------------------------
  // Widths and scale
  // ---------------------------------------------------------------
  localparam int CODE_W = 5;
  localparam int ADC_W = 12;
  localparam int PROD_W = 19;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h1f;
  localparam logic [CODE_W-1:0] CODE_RST = 5'h00;
  localparam logic [5:0] SCALE_DIV = 6'h21;          // 33 steps of the reference
  localparam logic [5:0] HYST_UP = 6'h02;            // Rising threshold offset

  // ---------------------------------------------------------------
  // Chopping period and duty
  // ---------------------------------------------------------------
  localparam int SYNC_PER_PERIOD = 128;
  localparam int PCNT_W = 8;
  localparam logic [PCNT_W-1:0] PCNT_LAST = 8'h7f;
  localparam logic [PCNT_W-1:0] DUTY_FULL = 8'h80;   // 100 %
  localparam logic [PCNT_W-1:0] DUTY_FLOOR = 8'h0c;  // 9.375 % of 128
  localparam logic [CODE_W-1:0] FLOOR_CODE = 5'h03;  // Codes up to here hit floor
  localparam logic [PCNT_W-1:0] DUTY_STEP = 8'h04;   // 3.125 % of 128

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FILT_NS = 200;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FCNT_W = 6;
  localparam logic [FCNT_W-1:0] FILT_LAST = FCNT_W'(FILT_CYC - 1);
  localparam int LAMP_OUT_S = 2;
  localparam longint LAMP_OUT_CYC = longint'(LAMP_OUT_S) * CLK_MHZ * 1000000;
  localparam int TCNT_W = 29;

  // ---------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MIN_AT_RAIL,   // Chopping off, current control only
    MIN_AT_REF,    // Current fixed at max, chopping only
    MIN_BETWEEN,   // Both methods
    MIN_UNUSED
  } ldfc_min_e;

  typedef enum logic [1:0] {ST_RUN, ST_SHDN, ST_FAULT} ldfc_state_e;

  typedef struct packed {
    logic lamp_out;
    logic buck_short;
  } ldfc_fault_s;
endpackage

// ===== verif/ldfc_host_model.sv
`timescale 1ns/1ps
// ------
// Host side stimulus
// ------
module ldfc_host_model import ldfc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Bench controls
  input wire logic sync_en,
  input wire logic [1:0] sense_mode,
  input wire logic shdn_req,
  // Toward the block, plus the sync rise count back to the bench
  output logic mode_sync_pulse,
  output logic lamp_current_sense,
  output logic shutdown_suspend_pin_n,
  output logic [6:0] rise_cnt
);
  logic [5:0] sense_cnt_r;
  // Sync toggles each cycle, stands still when off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_sync_pulse <= 1'b0;
      rise_cnt <= 7'h00;
    end else if (sync_en) begin
      mode_sync_pulse <= ~mode_sync_pulse;
      rise_cnt <= rise_cnt + {6'h00, ~mode_sync_pulse};
    end
  end
  // Shutdown pin from the host, registered like a real pad
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_suspend_pin_n <= 1'b1;
      sense_cnt_r <= 6'h00;
    end else begin
      shutdown_suspend_pin_n <= ~shdn_req;
      sense_cnt_r <= sense_cnt_r + 6'h01;
    end
  end
  // Sense: 1 healthy bursts, 2 bursts too short to count, else dark
  assign lamp_current_sense = (sense_mode == 2'h1) ? (sense_cnt_r < 6'h3c)
                            : (sense_mode == 2'h2) && (sense_cnt_r < 6'h28);
endmodule // ldfc_host_model

// ===== verif/test_lamp_dimming_fault_control.sv
`timescale 1ns/1ps
// ------
// Bench for the dimming and fault core
// ------
module test_lamp_dimming_fault_control import ldfc_pkg::*; ();
  localparam int LAMP = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [ADC_W-1:0] ctl = 12'h000;
  logic neg = 1'b0;
  logic shdn_req = 1'b0;
  logic mreg = 1'b0;
  logic uv = 1'b0;
  logic buck = 1'b0;
  logic sync_en = 1'b0;
  logic [1:0] smode = 2'h0;
  ldfc_min_e minl = MIN_BETWEEN;
  logic sync, sense, pin_n, pwm, gate, shdn, flag;
  logic [6:0] rcnt;
  logic [CODE_W-1:0] code, cur;
  ldfc_fault_s flt;
  int fail_count = 0;
  int samples_checked = 0;

  // Clock at 250 MHz
  always #2 clk_sys = ~clk_sys;

  ldfc_host_model ldfc_host_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .sync_en(sync_en), .sense_mode(smode), .shdn_req(shdn_req),
    .mode_sync_pulse(sync), .lamp_current_sense(sense),
    .shutdown_suspend_pin_n(pin_n), .rise_cnt(rcnt));
  ldfc_core #(.LAMP_OUT_CYCLES(LAMP)) ldfc_core_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .brightness_control_input(ctl), .brightness_reference_input(12'h840),
    .mode_negative_scale(neg), .mode_sync_pulse(sync), .min_level_setting(minl),
    .shutdown_suspend_pin_n(pin_n), .mode_reg_shutdown(mreg),
    .rail_undervoltage(uv), .lamp_current_sense(sense), .buck_short_detect(buck),
    .brightness_code(code), .current_code(cur), .chopping_pwm(pwm),
    .buck_gate_en(gate), .shutdown_active(shdn), .fault_latch(flt),
    .lamp_status_flag(flag));

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Waits for the 128th sync rise; a stalled counter ends the run
  task automatic boundary();
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge clk_sys);
      if (rcnt == 7'h00 && sync === 1'b1) break;
    end
    if (i == 600) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // Ramp at 128 steps of 2 cycles: on length times 2
  function automatic logic [31:0] on_cyc(input logic [4:0] c);
    return (c <= 5'h03) ? 32'h18 : ({27'h0, c} + 32'h1) * 32'h8;
  endfunction

  // One full period counted; gate follows pwm unless locked out
  task automatic duty(input logic [31:0] exp);
    int p;
    int g;
    p = 0;
    g = 0;
    repeat (256) begin
      @(posedge clk_sys);
      if (pwm === 1'b1) p++;
      if (gate === 1'b1) g++;
    end
    check("pwm_high", exp, p);
    check("gate_high", uv ? 32'h0 : exp, g);
  endtask

  // Two boundaries give the code time to settle and publish
  task automatic code_case(input logic [11:0] v, input logic [4:0] exp);
    ctl <= v;
    boundary();
    boundary();
    cyc(4);
    check("code", {27'h0, exp}, {27'h0, code});
    check("cur", {27'h0, exp}, {27'h0, cur});
    duty(on_cyc(exp));
  endtask

  task automatic min_case(input ldfc_min_e m, input logic [4:0] ec, input logic [31:0] ed);
    minl <= m;
    cyc(4);
    check("cur_min", {27'h0, ec}, {27'h0, cur});
    duty(ed);
  endtask

  // Main sequence
  initial begin
    int i;
    int k;
    cyc(8);
    check("code_rst", 32'h0, {27'h0, code});
    check("flt_rst", 32'h0, {30'h0, flt});
    reset_n <= 1'b1;
    sync_en <= 1'b1;
    smode <= 2'h1;
    code_case(12'h840, 5'h1f);
    code_case(12'h2a0, 5'h0a);
    boundary();
    ctl <= 12'h000;
    cyc(100);
    check("code_hold", 32'ha, {27'h0, code});
    code_case(12'h000, 5'h00);
    code_case(12'h2a0, 5'h09);
    min_case(MIN_AT_REF, 5'h1f, on_cyc(5'h09));
    min_case(MIN_AT_RAIL, 5'h09, 32'h100);
    min_case(MIN_UNUSED, 5'h09, on_cyc(5'h09));
    min_case(MIN_BETWEEN, 5'h09, on_cyc(5'h09));
    neg <= 1'b1;
    code_case(12'h000, 5'h1f);
    code_case(12'h2a0, 5'h16);
    code_case(12'h840, 5'h00);
    code_case(12'h2a0, 5'h15);
    uv <= 1'b1;
    cyc(4);
    duty(on_cyc(5'h15));
    uv <= 1'b0;
    for (k = 0; k < 2; k++) begin
      shdn_req <= (k == 0);
      mreg <= (k == 1);
      cyc(4);
      check("shdn", 32'h1, {31'h0, shdn});
      duty(32'h0);
      shdn_req <= 1'b0;
      mreg <= 1'b0;
      cyc(4);
      check("run", 32'h0, {31'h0, shdn});
    end
    buck <= 1'b1;
    cyc(4);
    check("buck_set", 32'h1, {31'h0, flt.buck_short});
    buck <= 1'b0;
    mreg <= 1'b1;
    cyc(4);
    check("buck_clr", 32'h0, {30'h0, flt});
    mreg <= 1'b0;
    smode <= 2'h2;
    for (i = 0; i < 3 * LAMP && flt.lamp_out !== 1'b1; i++) @(posedge clk_sys);
    if (i == 3 * LAMP) begin
      fail_count++;
      report_and_stop();
    end
    check("lo_time", 32'h1, {31'h0, (i > LAMP - 70) && (i < LAMP + 10)});
    check("flag_set", 32'h1, {31'h0, flag});
    cyc(4);
    duty(32'h0);
    shdn_req <= 1'b1;
    cyc(4);
    check("lo_clr", 32'h0, {30'h0, flt});
    check("flag_kept", 32'h1, {31'h0, flag});
    shdn_req <= 1'b0;
    smode <= 2'h1;
    cyc(4 * LAMP);
    check("no_fault", 32'h0, {30'h0, flt});
    reset_n <= 1'b0;
    cyc(2);
    check("flag_por", 32'h0, {31'h0, flag});
    check("code_por", 32'h0, {27'h0, code});
    report_and_stop();
  end
endmodule // test_lamp_dimming_fault_control
